// >>> rtl/cpk.sv
// Shared constants and types for the control, literal and table decode core
package cpk;
	// ------------------------------------------------------------
	// Register map, byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL  = 8'h00; // Run, prescaler owner, write arm
	localparam logic [7:0] ADDR_STAT  = 8'h04; // Flags, power flags, stack level
	localparam logic [7:0] ADDR_WORK  = 8'h08; // Working reg, table latch, bank
	localparam logic [7:0] ADDR_PC    = 8'h0c; // Program counter
	localparam logic [7:0] ADDR_PROD  = 8'h10; // Multiplier product
	localparam logic [7:0] ADDR_FSR01 = 8'h14; // Pointers 0 and 1
	localparam logic [7:0] ADDR_FSR2  = 8'h18; // Pointer 2
	localparam logic [7:0] ADDR_TPTR  = 8'h1c; // Table pointer
	localparam int CTRL_RUN  = 0; // Core executes when set
	localparam int CTRL_PSA  = 1; // Prescaler belongs to timer zero
	localparam int CTRL_WREN = 2; // Table write starts a memory write cycle
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// Status flag positions and reset values
	// ------------------------------------------------------------
	localparam int F_C  = 0;
	localparam int F_DC = 1;
	localparam int F_Z  = 2;
	localparam int F_OV = 3;
	localparam int F_N  = 4;
	localparam logic [4:0] STAT_RST = 5'h00;
	localparam logic       PWR_RST  = 1'b1; // Timeout and powerdown after reset
	// ------------------------------------------------------------
	// Whole-word opcodes
	// ------------------------------------------------------------
	localparam logic [15:0] OP_SLEEP  = 16'h0003;
	localparam logic [15:0] OP_WDTCLR = 16'h0004;
	localparam logic [15:0] OP_PUSH   = 16'h0005;
	localparam logic [15:0] OP_POP    = 16'h0006;
	localparam logic [15:0] OP_DAW    = 16'h0007;
	localparam logic [15:0] OP_SWRST  = 16'h00ff;
	localparam logic [3:0]  SEL_MOV   = 4'he; // Literal group selectors
	localparam logic [3:0]  SEL_AND   = 4'hb;
	localparam logic [3:0]  SEL_MUL   = 4'hd;
	localparam logic [3:0]  SEL_RETURN_WITH_LITERAL = 4'hc;
	localparam logic [3:0]  NIB_WORD2 = 4'hf; // Upper nibble of second words
	// Pipeline phase of the core
	typedef enum logic [1:0] {PH_EXEC, PH_FLUSH, PH_SECOND} ph_t;
endpackage

// >>> rtl/ctl_core.sv
// Control-flow, literal and table transfer execute core with register slave
`timescale 1ns/1ps
// What this block does
// - Port self-modify takes pin values, not latch
// - Timer zero write clears assigned prescaler
// - PC change or true test: two cycles
// - Lone second word runs as no-op
// - Started memory write always runs to end
// - Eight conditional branches, signed byte offset
// - Two-word call, optional shadow save
// - Two-word absolute jump loads program counter
// - Stack pop and push, one cycle
// - Interrupt return enables, return pops address
// - Return with literal loads working register
// - Watchdog clear, standby update power flags
// - Add and subtract literal set five flags
// - Literal logic ops set zero, negative
// - Load literal into working, no flags
// - Load bank select low nibble
// - Multiply literal, flags unchanged
// - Two-word pointer load, 12-bit literal
// - Table read into latch, pointer modes
// - Table write from latch, pointer modes
// - Zero word and 1111 words are no-ops
module ctl_core #(
	parameter int STACK_DEPTH  = 31, // Return stack levels
	parameter int WRITE_CYCLES = 16  // Length of one memory write cycle
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [15:0] instr_word,
	output logic [20:0]      pc_r,
	input  wire logic [7:0]  tbl_rdata,
	output logic [20:0]      tbl_addr_r,
	output logic [7:0]       tbl_wdata_r,
	output logic             tbl_rd_r,
	output logic             tbl_we_r,
	output logic             write_busy_r,
	input  wire logic [7:0]  port_pins,
	input  wire logic [7:0]  port_latch,
	input  wire logic        port_rmw,
	output logic [7:0]       port_operand_r,
	input  wire logic        timer_zero_count_dest_write,
	output logic             prescaler_clear_r,
	output logic             wdt_clear_r,
	output logic             sleep_r
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Literal ALU: returns {result, flags}
	function automatic logic [12:0] lit_alu(input logic [3:0] sel, input logic [7:0] w,
			input logic [7:0] k, input logic [4:0] st);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		logic [4:0] f;
		s = 9'h0;
		h = 5'h0;
		r = w;
		f = st;
		case (sel)
			4'hf: begin // Add
				s = {1'b0, w} + {1'b0, k};
				h = {1'b0, w[3:0]} + {1'b0, k[3:0]};
				r = s[7:0];
				f[cpk::F_C] = s[8];
				f[cpk::F_DC] = h[4];
				f[cpk::F_OV] = (w[7] == k[7]) && (r[7] != w[7]);
			end
			4'h8: begin // Literal minus working, carry means no borrow
				s = {1'b0, k} - {1'b0, w};
				h = {1'b0, k[3:0]} - {1'b0, w[3:0]};
				r = s[7:0];
				f[cpk::F_C] = !s[8];
				f[cpk::F_DC] = !h[4];
				f[cpk::F_OV] = (k[7] != w[7]) && (r[7] != k[7]);
			end
			4'hb: r = w & k;
			4'h9: r = w | k;
			4'ha: r = w ^ k;
			cpk::SEL_MOV: r = k;
			4'h0: begin // Decimal adjust, only carry moves
				s = {1'b0, w} + ((w[3:0] > 4'h9 || st[cpk::F_DC]) ? 9'h006 : 9'h000);
				h[0] = s[8];
				if (s[7:4] > 4'h9 || st[cpk::F_C] || s[8]) begin
					s = {1'b0, s[7:0]} + 9'h060;
				end
				r = s[7:0];
				f[cpk::F_C] = st[cpk::F_C] | h[0] | s[8];
			end
			default: ; // Multiply and others keep working and flags
		endcase
		if (sel inside {4'hf, 4'h8, 4'hb, 4'h9, 4'ha}) begin
			f[cpk::F_Z] = (r == 8'h00);
			f[cpk::F_N] = r[7];
		end
		return {r, f};
	endfunction

	// Branch test: 00 zero, 01 carry, 10 overflow, 11 negative; bit 0 inverts
	function automatic logic cond_met(input logic [2:0] cc, input logic [4:0] st);
		logic b;
		case (cc[2:1])
			2'd0:    b = st[cpk::F_Z];
			2'd1:    b = st[cpk::F_C];
			2'd2:    b = st[cpk::F_OV];
			default: b = st[cpk::F_N];
		endcase
		return b ^ cc[0];
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	cpk::ph_t    ph_r;           // Pipeline phase
	logic [15:0] first_r;        // First word of a two-word op
	logic [7:0]  w_r;            // Working register
	logic [4:0]  stat_r;         // N OV Z DC C
	logic [3:0]  bsr_r;          // Bank select register
	logic [7:0]  w_s;            // Shadow copies
	logic [4:0]  stat_s;
	logic [3:0]  bsr_s;
	logic        to_r;           // Timeout flag
	logic        pd_r;           // Powerdown flag
	logic        gieh_r;         // Global high interrupt enable
	logic        giel_r;         // Peripheral low interrupt enable
	logic [15:0] prod_r;         // Product
	logic [11:0] fsr_r [3];      // Indirect address pointers
	logic [20:0] tptr_r;         // Table pointer
	logic [7:0]  tablat_r;       // Table latch
	logic [20:0] stk_r [STACK_DEPTH];
	logic [4:0]  sp_r;           // Stack level, 0 is empty
	logic [2:0]  ctrl_r;         // Control register
	logic        soft_rst_r;     // One-cycle software reset
	logic [15:0] wr_cnt_r;       // Memory write cycle counter
	logic [15:0] wr_cnt_nxt;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire         core_rst  = !aresetn || soft_rst_r;
	wire         run       = ctrl_r[cpk::CTRL_RUN] && !write_busy_r;
	wire         in_exec   = run && (ph_r == cpk::PH_EXEC);
	wire         in_second = run && (ph_r == cpk::PH_SECOND);
	wire [7:0]   k         = instr_word[7:0];
	wire [3:0]   sel       = instr_word[11:8];
	wire         is_bcc    = instr_word[15:11] == 5'h1c;
	wire         is_bra    = instr_word[15:11] == 5'h1a;
	wire         is_relative_subroutine_call  = instr_word[15:11] == 5'h1b;
	wire         is_call   = instr_word[15:9] == 7'h76;
	wire         is_absolute_jump   = instr_word[15:8] == 8'hef;
	wire         is_load_indirect_pointer   = instr_word[15:6] == 10'h3b8;
	wire         is_ret    = instr_word[15:2] == 14'h0004;
	wire         is_return_with_literal  = instr_word[15:8] == 8'h0c;
	wire         is_tbl    = instr_word[15:3] == 13'h0001;
	wire         is_load_bank_select  = instr_word[15:4] == 12'h010;
	wire         is_lit    = instr_word[15:12] == 4'h0 && sel[3];
	wire         is_daw    = instr_word == cpk::OP_DAW;
	wire         br_taken  = is_bcc && cond_met(instr_word[10:8], stat_r);
	wire         first_call = first_r[15:9] == 7'h76;
	wire [20:0]  pc_inc    = pc_r + 21'd2;
	wire [20:0]  br8       = pc_inc + {{12{k[7]}}, k, 1'b0};
	wire [20:0]  br11      = pc_inc + {{9{instr_word[10]}}, instr_word[10:0], 1'b0};
	wire [20:0]  far_addr  = {instr_word[11:0], first_r[7:0], 1'b0};
	wire [20:0]  return_stack_top       = (sp_r == 5'd0) ? 21'h0 : stk_r[sp_r - 5'd1];
	wire [12:0]  alu_out   = lit_alu(sel, w_r, k, stat_r);
	// Table pointer: mode 3 bumps before use, 1 and 2 after
	wire [20:0]  tp_use    = (instr_word[1:0] == 2'd3) ? tptr_r + 21'd1 : tptr_r;
	wire [20:0]  tp_nxt    = (instr_word[1:0] == 2'd2) ? tptr_r - 21'd1 :
				(instr_word[1:0] == 2'd0) ? tptr_r : tptr_r + 21'd1;
	wire         push_en   = (in_exec && (is_relative_subroutine_call || instr_word == cpk::OP_PUSH)) ||
				(in_second && first_call);
	wire         pop_en    = in_exec && (instr_word == cpk::OP_POP || is_ret || is_return_with_literal);
	wire         wr_start  = in_exec && is_tbl && instr_word[2] && ctrl_r[cpk::CTRL_WREN];

	// ------------------------------------------------------------
	// Return stack
	// ------------------------------------------------------------
	// Full stack drops pushes, empty stack ignores pops
	always_ff @(posedge aclk) begin
		if (core_rst) begin
			sp_r <= 5'd0;
		end else if (push_en && sp_r < 5'(STACK_DEPTH)) begin
			stk_r[sp_r] <= pc_inc;
			sp_r <= sp_r + 5'd1;
		end else if (pop_en && sp_r != 5'd0) begin
			sp_r <= sp_r - 5'd1;
		end
	end

	// ------------------------------------------------------------
	// Execute
	// ------------------------------------------------------------
	// Pulses default low every cycle
	always_ff @(posedge aclk) begin
		tbl_rd_r <= 1'b0;
		tbl_we_r <= 1'b0;
		wdt_clear_r <= 1'b0;
		sleep_r <= 1'b0;
		if (core_rst) begin
			ph_r <= cpk::PH_EXEC;
			pc_r <= 21'h0;
			first_r <= 16'h0;
			w_r <= 8'h00;
			stat_r <= cpk::STAT_RST;
			bsr_r <= 4'h0;
			w_s <= 8'h00;
			stat_s <= cpk::STAT_RST;
			bsr_s <= 4'h0;
			to_r <= cpk::PWR_RST;
			pd_r <= cpk::PWR_RST;
			gieh_r <= 1'b0;
			giel_r <= 1'b0;
			prod_r <= 16'h0;
			fsr_r <= '{default: 12'h0};
			tptr_r <= 21'h0;
			tablat_r <= 8'h00;
			tbl_addr_r <= 21'h0;
			tbl_wdata_r <= 8'h00;
		end else if (run) begin
			case (ph_r)
				cpk::PH_FLUSH: begin // Discarded fetch runs as no-op
					ph_r <= cpk::PH_EXEC;
					if (tbl_rd_r) begin
						tablat_r <= tbl_rdata;
					end
				end
				cpk::PH_SECOND: begin // Second word consumed by its first
					ph_r <= cpk::PH_EXEC;
					pc_r <= pc_inc;
					if (first_r[15:8] == 8'hef || first_call) begin
						pc_r <= far_addr;
					end
					if (first_call && first_r[8]) begin
						w_s <= w_r;
						stat_s <= stat_r;
						bsr_s <= bsr_r;
					end
					if (first_r[15:8] == 8'hee && first_r[5:4] != 2'd3) begin
						fsr_r[first_r[5:4]] <= {first_r[3:0], instr_word[7:0]};
					end
				end
				cpk::PH_EXEC: begin
					pc_r <= pc_inc;
					if (is_bcc) begin // Not taken: one cycle, flags kept
						if (br_taken) begin
							pc_r <= br8;
							ph_r <= cpk::PH_FLUSH;
						end
					end else if (is_bra || is_relative_subroutine_call) begin
						pc_r <= br11;
						ph_r <= cpk::PH_FLUSH;
					end else if (is_call || is_absolute_jump || is_load_indirect_pointer) begin
						first_r <= instr_word;
						ph_r <= cpk::PH_SECOND;
					end else if (is_ret || is_return_with_literal) begin
						pc_r <= return_stack_top;
						ph_r <= cpk::PH_FLUSH;
						if (is_return_with_literal) begin
							w_r <= k;
						end
						if (is_ret && !instr_word[1]) begin
							gieh_r <= 1'b1;
							giel_r <= 1'b1;
						end
						if (is_ret && instr_word[0]) begin
							w_r <= w_s;
							stat_r <= stat_s;
							bsr_r <= bsr_s;
						end
					end else if (is_tbl) begin
						tbl_addr_r <= tp_use;
						tptr_r <= tp_nxt;
						ph_r <= cpk::PH_FLUSH;
						tbl_rd_r <= !instr_word[2];
						tbl_we_r <= instr_word[2];
						tbl_wdata_r <= tablat_r;
					end else if (is_lit || is_daw) begin
						{w_r, stat_r} <= alu_out;
						if (sel == cpk::SEL_MUL) begin
							prod_r <= w_r * k;
						end
					end else if (is_load_bank_select) begin
						bsr_r <= instr_word[3:0];
					end else if (instr_word == cpk::OP_WDTCLR) begin
						to_r <= 1'b1;
						pd_r <= 1'b1;
						wdt_clear_r <= 1'b1;
					end else if (instr_word == cpk::OP_SLEEP) begin
						to_r <= 1'b1;
						pd_r <= 1'b0;
						sleep_r <= 1'b1;
					end
					// Zero word, lone 1111 words, push and pop: nothing more
				end
				default: ph_r <= cpk::PH_EXEC;
			endcase
		end
	end

	// Software reset strikes one cycle after its opcode
	always_ff @(posedge aclk) begin
		soft_rst_r <= aresetn && in_exec && instr_word == cpk::OP_SWRST;
	end

	// ------------------------------------------------------------
	// Memory write cycle and side effects
	// ------------------------------------------------------------
	// Counter sees only the power reset, so nothing can cut a write short
	assign wr_cnt_nxt = (wr_cnt_r != 16'h0) ? wr_cnt_r - 16'd1 :
			wr_start ? 16'(WRITE_CYCLES) : 16'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_cnt_r <= 16'h0;
			write_busy_r <= 1'b0;
			port_operand_r <= 8'h00;
			prescaler_clear_r <= 1'b0;
		end else begin
			wr_cnt_r <= wr_cnt_nxt;
			write_busy_r <= wr_cnt_nxt != 16'h0;
			port_operand_r <= port_rmw ? port_pins : port_latch;
			prescaler_clear_r <= timer_zero_count_dest_write && ctrl_r[cpk::CTRL_PSA];
		end
	end

	// ------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------
	wire         aw_ok  = awaddr[7:5] == 3'b000;
	wire         ar_ok  = araddr[7:5] == 3'b000;
	wire [7:0]   ra     = {araddr[7:2], 2'b00};
	wire [31:0]  rd_word =
		(ra == cpk::ADDR_CTRL)  ? {29'h0, ctrl_r} :
		(ra == cpk::ADDR_STAT)  ? {11'h0, sp_r, 3'h0, write_busy_r, giel_r, gieh_r,
				pd_r, to_r, 3'h0, stat_r} :
		(ra == cpk::ADDR_WORK)  ? {12'h0, bsr_r, tablat_r, w_r} :
		(ra == cpk::ADDR_PC)    ? {11'h0, pc_r} :
		(ra == cpk::ADDR_PROD)  ? {16'h0, prod_r} :
		(ra == cpk::ADDR_FSR01) ? {4'h0, fsr_r[1], 4'h0, fsr_r[0]} :
		(ra == cpk::ADDR_FSR2)  ? {20'h0, fsr_r[2]} :
		(ra == cpk::ADDR_TPTR)  ? {11'h0, tptr_r} : 32'h0;

	// Write: address and data taken together, answer one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= cpk::RESP_OKAY;
			ctrl_r <= cpk::CTRL_RST;
		end else begin
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready <= awvalid && wvalid && !awready && !bvalid;
			if (awready) begin
				bvalid <= 1'b1;
				bresp <= aw_ok ? cpk::RESP_OKAY : cpk::RESP_SLVERR;
				if ({awaddr[7:2], 2'b00} == cpk::ADDR_CTRL && wstrb[0]) begin
					ctrl_r <= wdata[2:0];
				end
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read: data registered in the cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= cpk::RESP_OKAY;
		end else begin
			arready <= arvalid && !arready && !rvalid;
			if (arready) begin
				rvalid <= 1'b1;
				rdata <= rd_word;
				rresp <= ar_ok ? cpk::RESP_OKAY : cpk::RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (core_rst);

	AST_BR_TAKEN: assert property (in_exec && br_taken |=>
		pc_r == $past(br8) && ph_r == cpk::PH_FLUSH) else $error("branch target wrong");
	AST_BR_NOT: assert property (in_exec && is_bcc && !br_taken |=>
		pc_r == $past(pc_inc) && stat_r == $past(stat_r)) else $error("untaken branch");
	AST_REL: assert property (in_exec && is_bra |=>
		pc_r == $past(br11) ##1 ph_r == cpk::PH_EXEC) else $error("relative jump");
	AST_FAR: assert property (in_exec && is_absolute_jump ##1 run |=>
		pc_r == {$past(instr_word[11:0]), $past(instr_word[7:0], 2), 1'b0})
		else $error("absolute jump target");
	AST_PUSH: assert property (push_en && sp_r < 5'(STACK_DEPTH) |=>
		sp_r == $past(sp_r) + 5'd1 && return_stack_top == $past(pc_inc)) else $error("push");
	AST_RET: assert property (in_exec && is_ret && sp_r != 5'd0 |=>
		pc_r == $past(return_stack_top) && sp_r == $past(sp_r) - 5'd1) else $error("return pop");
	AST_LOAD_LITERAL_WORKING: assert property (in_exec && is_lit && sel == cpk::SEL_MOV |=>
		w_r == $past(k) && stat_r == $past(stat_r)) else $error("load literal");
	AST_AND: assert property (in_exec && is_lit && sel == cpk::SEL_AND |=>
		w_r == $past(w_r & k) && stat_r[cpk::F_Z] == (w_r == 8'h00)
		&& stat_r[cpk::F_C] == $past(stat_r[cpk::F_C])) else $error("and flags");
	AST_WR: assert property (wr_cnt_r != 16'h0 |=>
		wr_cnt_r == $past(wr_cnt_r) - 16'd1 && !tbl_rd_r) else $error("write cut");
	AST_W2NOP: assert property (in_exec && instr_word[15:12] == cpk::NIB_WORD2 |=>
		w_r == $past(w_r) && pc_r == $past(pc_inc)) else $error("lone second word");
	AST_PSC: assert property (timer_zero_count_dest_write && ctrl_r[cpk::CTRL_PSA] |=>
		prescaler_clear_r) else $error("prescaler not cleared");

	COV_BR: cover property (in_exec && br_taken);
	COV_CALL: cover property (in_second && first_call && first_r[8]);
	COV_WR: cover property (wr_start ##1 write_busy_r);
endmodule // ctl_core

// >>> sim/testbench.sv
// Self-checking bench for the control, literal and table decode core
`timescale 1ns/1ps
module testbench;
	// ------------------------------------------------------------
	// Signals, program memory and expectation queues
	// ------------------------------------------------------------
	logic        aclk, aresetn;                    // Clock, reset
	logic [7:0]  awaddr, araddr;                   // Bus addresses
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rdata;                     // Bus data
	logic [3:0]  wstrb;                            // Byte lanes
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;                     // Responses
	logic [15:0] instr_word;                       // Fetched word
	logic [20:0] pc_r, tbl_addr_r;                 // Fetch and table address
	logic [7:0]  tbl_rdata, tbl_wdata_r, port_pins, port_latch, port_operand_r;
	logic        tbl_rd_r, tbl_we_r, write_busy_r, port_rmw, timer_zero_count_dest_write;
	logic        prescaler_clear_r, wdt_clear_r, sleep_r;
	logic [15:0] rom [0:31];                       // Word-addressed program store
	logic [33:0] rd_q [$];                         // Expected {resp, data}
	logic [1:0]  b_q [$];                          // Expected write responses
	logic [8:0]  side_q [$];                       // Expected {clear, operand}
	logic [31:0] seed;                             // Random source state
	logic        live;                             // Side traffic running
	int          err_count, samples_checked, wdt_seen, we_seen, busy_len, i;
	// Program: literals, multiply, bank, pointer, table, branches, call, loop
	localparam logic [15:0] PROG [19] = '{16'h0e15, 16'h0f10, 16'h0d03, 16'h0104,
		16'hee11, 16'hf023, 16'h0004, 16'h0009, 16'h000c, 16'he003, 16'he101,
		16'h0e99, 16'hef0e, 16'hf000, 16'hd801, 16'hd7ff, 16'h0b0f, 16'hf123,
		16'h0012};
	localparam logic [7:0] RA [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h18, 8'h1c, 8'h20};
	localparam logic [33:0] RE [9] = '{34'h007, 34'h300, 34'h41505, 34'h1e, 34'h6f,
		34'h1230000, 34'h0, 34'h1, 34'h200000000};

	ctl_core #(.WRITE_CYCLES(4)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.instr_word(instr_word), .pc_r(pc_r), .tbl_rdata(tbl_rdata),
		.tbl_addr_r(tbl_addr_r), .tbl_wdata_r(tbl_wdata_r), .tbl_rd_r(tbl_rd_r),
		.tbl_we_r(tbl_we_r), .write_busy_r(write_busy_r), .port_pins(port_pins),
		.port_latch(port_latch), .port_rmw(port_rmw), .port_operand_r(port_operand_r),
		.timer_zero_count_dest_write(timer_zero_count_dest_write), .prescaler_clear_r(prescaler_clear_r),
		.wdt_clear_r(wdt_clear_r), .sleep_r(sleep_r));

	// Program memory answers combinationally, bytes little-endian
	assign instr_word = rom[pc_r[5:1]];
	assign tbl_rdata  = tbl_addr_r[0] ? rom[tbl_addr_r[5:1]][15:8] : rom[tbl_addr_r[5:1]][7:0];

	// Free-running bench clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Shift register for random side inputs
	function automatic logic [31:0] load_indirect_pointer(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// ------------------------------------------------------------
	// Compare and closing tasks
	// ------------------------------------------------------------
	task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: bus got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: pins got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus master tasks; each is entered just after a rising edge
	// ------------------------------------------------------------
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		b_q.push_back(r);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do begin @(posedge aclk); n++; end while (!(awready && wready) && n < 50);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		bready  <= 1'b1;
		do begin @(posedge aclk); n++; end while (!bvalid && n < 50);
		bready <= 1'b0;
		// A stuck handshake ends the run
		if (n >= 50) begin
			err_count++;
			stop_test();
		end
		@(posedge aclk);
	endtask

	task automatic axi_read(input logic [7:0] a, input logic [33:0] exp);
		int n;
		n = 0;
		rd_q.push_back(exp);
		araddr  <= a;
		arvalid <= 1'b1;
		do begin @(posedge aclk); n++; end while (!arready && n < 50);
		arvalid <= 1'b0;
		rready  <= 1'b1;
		do begin @(posedge aclk); n++; end while (!rvalid && n < 50);
		rready <= 1'b0;
		if (n >= 50) begin
			err_count++;
			stop_test();
		end
		@(posedge aclk);
	endtask

	// ------------------------------------------------------------
	// Watchers: bus answers at the handshake edge, pulses mid-cycle
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (rvalid && rready && rd_q.size() > 0) begin
			chk_bus({rresp, rdata}, rd_q.pop_front());
		end
		if (bvalid && bready && b_q.size() > 0) begin
			chk_bus({32'h0, bresp}, {32'h0, b_q.pop_front()});
		end
	end

	always @(negedge aclk) begin
		// Registered outputs reflect the inputs seen at the last edge
		if (side_q.size() > 0) begin
			chk_pin({7'h0, prescaler_clear_r, port_operand_r}, {7'h0, side_q.pop_front()});
		end
		if (tbl_we_r) begin
			chk_pin({tbl_addr_r[7:0], tbl_wdata_r}, 16'h0115);
		end
		wdt_seen = wdt_seen + int'(wdt_clear_r);
		we_seen  = we_seen + int'(tbl_we_r);
		busy_len = busy_len + int'(write_busy_r);
	end

	// Random side traffic; expectations noted from the values the edge sees
	always @(posedge aclk) begin
		if (live) begin
			side_q.push_back({timer_zero_count_dest_write, port_rmw ? port_pins : port_latch});
			seed = load_indirect_pointer(seed);
			port_pins       <= seed[7:0];
			port_latch      <= seed[15:8];
			port_rmw        <= seed[16];
			timer_zero_count_dest_write <= seed[17];
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, port_rmw, timer_zero_count_dest_write, live} = '0;
		{awaddr, araddr, wdata, wstrb, port_pins, port_latch} = '0;
		{err_count, samples_checked, wdt_seen, we_seen, busy_len} = '0;
		seed = 32'h4654;
		for (i = 0; i < 32; i++) begin
			rom[i] = (i < 19) ? PROG[i] : 16'h0000;
		end
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_read(RA[0], 34'h0);                      // Control resets idle
		axi_write(8'h08, 32'hffff_ffff, cpk::RESP_OKAY);   // Read-only place ignored
		axi_write(8'h20, 32'h0, cpk::RESP_SLVERR);         // Unmapped place refused
		axi_write(cpk::ADDR_CTRL, 32'h7, cpk::RESP_OKAY);  // Run, prescaler owner, write arm
		live <= 1'b1;
		// Program runs into its closing self-loop well within this time
		repeat (80) @(posedge aclk);
		for (i = 0; i < 9; i++) begin
			axi_read(RA[i], RE[i]);
		end
		chk_pin(16'(wdt_seen), 16'h1);
		chk_pin(16'(we_seen), 16'h1);
		chk_pin(16'(busy_len), 16'h4);
		stop_test();
	end
endmodule // testbench
